// >>> tar_cfg.svh
/*
  register indices, field positions, masks and reset values of the
  assist register update block; assumes inclusion by the design and its bench
*/
`ifndef TAR_CFG_SVH
`define TAR_CFG_SVH
// register index; the byte address on the bus is four times the index
`define TAR_IX_SEL   4'h0
`define TAR_IX_AR2   4'h1
`define TAR_IX_AR3   4'h2
`define TAR_IX_AR4   4'h3
`define TAR_IX_AR5   4'h4
`define TAR_IX_AR6   4'h5
`define TAR_IX_AR7   4'h6
`define TAR_IX_AR8   4'h7
`define TAR_IX_IMPL  4'h8
`define TAR_IX_CTX   4'h9
`define TAR_IX_ELC   4'hA
`define TAR_IX_ESC   4'hB
`define TAR_NREG     12
// writable bits of each register, reserved bits read zero
`define TAR_MSK_SEL  32'h00000000
`define TAR_MSK_AR2  32'hFFFFF060
`define TAR_MSK_AR3  32'hFFFFF3FF
`define TAR_MSK_AR4  32'h10030F7F
`define TAR_MSK_AR5  32'h800000FF
`define TAR_MSK_AR6  32'h3FFF0001
`define TAR_MSK_AR7  32'h0000000F
`define TAR_MSK_AR8  32'hC00000FF
`define TAR_MSK_IMPL 32'h00000001
`define TAR_MSK_CTX  32'h00033FFF
`define TAR_MSK_EXT  32'h80003FFF
// field positions
`define TAR_SEL_ASEL 28
`define TAR_SEL_ENTRY_SELECT 16
`define TAR_SEL_NV   0
`define TAR_AR2_EPN  12
`define TAR_AR2_X0   6
`define TAR_AR2_X1   5
`define TAR_AR3_RPN  12
`define TAR_AR3_USR  6
`define TAR_AR3_PRM  0
`define TAR_AR4_ASEL 28
`define TAR_AR4_X0D  1
`define TAR_AR4_X1D  0
`define TAR_AR6_PID  16
`define TAR_AR6_SAS  0
`define TAR_AR8_TGS  31
`define TAR_AR8_VF   30
`define TAR_AR8_LPID 0
`define TAR_IMPL_UEN 0
`define TAR_CTX_PID  0
`define TAR_CTX_IS   16
`define TAR_CTX_DS   17
`define TAR_EXT_PID  0
`define TAR_EXT_EAS  31
`define TAR_EA_PAGE  12
// reset values
`define TAR_REG_RST  32'h00000000
`define TAR_NV_RST   2'h0
`endif

// >>> tar_pkg.sv
/*
  types of the assist register update block; assumes the core's
  translation arrays deliver a selected entry as tar_entry_t
*/
package tar_pkg;
  typedef struct packed {
    logic [19:0] effective_page_number;
    logic [5:0]  perm;
    logic [3:0]  user;
    logic [19:0] rpnLo;
    logic [3:0]  rpnHi;
    logic        x0;
    logic        x1;
    logic        translation_guest_state;
    logic        vf;
    logic [7:0]  translation_partition_id;
    logic        arr;
    logic [1:0]  way;
    logic [5:0]  idx;
  } tar_entry_t;

  typedef struct packed {
    logic        instErr;
    logic        dataErr;
    logic        srchHit;
    logic        srchMiss;
    logic        entryRead;
    logic        extLoad;
    logic        extStore;
    logic [31:0] addr;
  } tar_evt_t;

  typedef enum logic [2:0] {
    EV_NONE,
    EV_ERR,
    EV_HIT,
    EV_MISS,
    EV_READ
  } tar_kind_t;
endpackage : tar_pkg

// >>> tar_update.sv
/*
  hardware update of the translation assist registers, with an APB slave
  for software; events and the selected entry come from core logic on
  clk_sys as one-cycle pulses, at most one event kind meant per cycle
*/
// Operation
// - misses clear permissions, user, low real page
// - effective page from address or entry
// - upper real page only when enabled
// - search space from external context or state
// - search pid from external context or pid
// - next victim kept per set
// - faulting address is the missing access address
`timescale 1ns/100ps
`include "tar_cfg.svh"
module tar_update import tar_pkg::*; #(
  parameter int NV_SETS = 64
) (
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire tar_evt_t                     ev,
  input  wire tar_entry_t                   entry,
  output logic      [`TAR_NREG-1:0][31:0]   regView
);
  localparam int SETW = $clog2(NV_SETS);

  if (NV_SETS < 2 || (1 << SETW) != NV_SETS || SETW > 20) begin : g_chk
    $error("NV_SETS must be a power of two from 2 to 2**20");
  end

  logic [1:0]              rstQ;
  logic                    rstn;
  logic [`TAR_NREG-1:0][31:0] regQ;
  logic [1:0]              nvMem [NV_SETS];
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  tar_kind_t               kind;
  logic [SETW-1:0]         setIx;
  logic [1:0]              nvCur;
  logic [31:0]             selD;
  logic                    upEn;
  logic                    defSel;
  logic                    addrOk;
  logic [3:0]              ix;
  logic                    wrEn;
  logic [31:0]             byteMsk;

  function automatic logic [31:0] maskOf(input logic [3:0] i);
    case (i)
      `TAR_IX_AR2:  maskOf = `TAR_MSK_AR2;
      `TAR_IX_AR3:  maskOf = `TAR_MSK_AR3;
      `TAR_IX_AR4:  maskOf = `TAR_MSK_AR4;
      `TAR_IX_AR5:  maskOf = `TAR_MSK_AR5;
      `TAR_IX_AR6:  maskOf = `TAR_MSK_AR6;
      `TAR_IX_AR7:  maskOf = `TAR_MSK_AR7;
      `TAR_IX_AR8:  maskOf = `TAR_MSK_AR8;
      `TAR_IX_IMPL: maskOf = `TAR_MSK_IMPL;
      `TAR_IX_CTX:  maskOf = `TAR_MSK_CTX;
      `TAR_IX_ELC,
      `TAR_IX_ESC:  maskOf = `TAR_MSK_EXT;
      default:      maskOf = `TAR_MSK_SEL;
    endcase
  endfunction : maskOf

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstQ <= 2'h0;
    end else begin
      rstQ <= {rstQ[0], 1'b1};
    end
  end
  assign rstn = rstQ[1];

  // errors outrank a hit, a hit a miss, a miss a read
  always_comb begin
    kind = EV_NONE;
    if (ev.instErr || ev.dataErr) begin
      kind = EV_ERR;
    end else if (ev.srchHit) begin
      kind = EV_HIT;
    end else if (ev.srchMiss) begin
      kind = EV_MISS;
    end else if (ev.entryRead) begin
      kind = EV_READ;
    end
  end

  assign setIx  = ev.addr[`TAR_EA_PAGE +: SETW];
  assign nvCur  = nvMem[setIx];
  assign upEn   = regQ[`TAR_IX_IMPL][`TAR_IMPL_UEN];
  assign defSel = regQ[`TAR_IX_AR4][`TAR_AR4_ASEL];

  // victim and entry-select word for each event kind
  always_comb begin
    selD = regQ[`TAR_IX_SEL];
    case (kind)
      EV_ERR, EV_MISS: begin
        selD = `TAR_REG_RST;
        selD[`TAR_SEL_ASEL] = defSel;
        if (!defSel) begin
          selD[`TAR_SEL_ENTRY_SELECT +: 6] = {4'h0, nvCur};
          selD[`TAR_SEL_NV +: 2]   = nvCur + 2'h1;
        end
      end
      EV_HIT: begin
        selD = `TAR_REG_RST;
        selD[`TAR_SEL_ASEL] = entry.arr;
        if (!entry.arr) begin
          selD[`TAR_SEL_ENTRY_SELECT +: 6] = {4'h0, entry.way};
          selD[`TAR_SEL_NV +: 2]   = nvCur;
        end else begin
          selD[`TAR_SEL_ENTRY_SELECT +: 6] = entry.idx;
        end
      end
      EV_READ: begin
        selD[`TAR_SEL_NV +: 2] = entry.arr ? 2'h0 : nvCur;
      end
      default: begin
        selD = regQ[`TAR_IX_SEL];
      end
    endcase
  end

  // next victim per set; only errors and misses with the first array as default step it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NV_SETS; i++) begin
        nvMem[i] <= `TAR_NV_RST;
      end
    end else if ((kind == EV_ERR || kind == EV_MISS) && !defSel) begin
      nvMem[setIx] <= nvCur + 2'h1;
    end
  end

  // bus decode; full words at index times four
  assign ix      = paddr[5:2];
  assign addrOk  = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0) && (ix < 4'hC);
  assign byteMsk = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wrEn    = psel && penable && pready_q && pwrite && addrOk;

  // zero wait states: answer in the first access cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `TAR_REG_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !addrOk;
      prdata_q  <= (psel && !penable && !pwrite && addrOk) ? regQ[ix] : `TAR_REG_RST;
    end
  end

  // register file; a hardware event in the cycle of a software write wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regQ <= {`TAR_NREG{`TAR_REG_RST}};
    end else begin
      if (wrEn) begin
        // read-only and reserved bits keep their value, so a write to SEL is ignored
        regQ[ix] <= (regQ[ix] & ~(byteMsk & maskOf(ix))) | (pwdata & byteMsk & maskOf(ix));
      end
      if (kind != EV_NONE) begin
        regQ[`TAR_IX_SEL] <= selD;
      end
      if (kind == EV_ERR || kind == EV_MISS) begin
        regQ[`TAR_IX_AR3] <= `TAR_REG_RST;
        regQ[`TAR_IX_AR2][`TAR_AR2_X0] <= regQ[`TAR_IX_AR4][`TAR_AR4_X0D];
        regQ[`TAR_IX_AR2][`TAR_AR2_X1] <= regQ[`TAR_IX_AR4][`TAR_AR4_X1D];
        if (upEn) begin
          regQ[`TAR_IX_AR7] <= `TAR_REG_RST;
        end
      end
      if (kind == EV_ERR) begin
        regQ[`TAR_IX_AR2][`TAR_AR2_EPN +: 20] <= ev.addr[31:12];
        if (ev.dataErr && ev.extLoad) begin
          regQ[`TAR_IX_AR6][`TAR_AR6_SAS] <= regQ[`TAR_IX_ELC][`TAR_EXT_EAS];
        end else if (ev.dataErr && ev.extStore) begin
          regQ[`TAR_IX_AR6][`TAR_AR6_SAS] <= regQ[`TAR_IX_ESC][`TAR_EXT_EAS];
        end else if (ev.dataErr) begin
          regQ[`TAR_IX_AR6][`TAR_AR6_SAS] <= regQ[`TAR_IX_CTX][`TAR_CTX_DS];
        end else begin
          regQ[`TAR_IX_AR6][`TAR_AR6_SAS] <= regQ[`TAR_IX_CTX][`TAR_CTX_IS];
        end
        if (ev.extLoad) begin
          regQ[`TAR_IX_AR6][`TAR_AR6_PID +: 14] <= regQ[`TAR_IX_ELC][`TAR_EXT_PID +: 14];
        end else if (ev.extStore) begin
          regQ[`TAR_IX_AR6][`TAR_AR6_PID +: 14] <= regQ[`TAR_IX_ESC][`TAR_EXT_PID +: 14];
        end else begin
          regQ[`TAR_IX_AR6][`TAR_AR6_PID +: 14] <= regQ[`TAR_IX_CTX][`TAR_CTX_PID +: 14];
        end
      end
      if (kind == EV_HIT || kind == EV_READ) begin
        regQ[`TAR_IX_AR3] <= {entry.rpnLo, 2'h0, entry.user, entry.perm};
        regQ[`TAR_IX_AR2][`TAR_AR2_X0] <= entry.x0;
        regQ[`TAR_IX_AR2][`TAR_AR2_X1] <= entry.x1;
        // the first array indexes by low page bits, so those stay as searched
        if (!entry.arr) begin
          regQ[`TAR_IX_AR2][`TAR_AR2_EPN +: 20] <=
            {entry.effective_page_number[19:7], regQ[`TAR_IX_AR2][`TAR_AR2_EPN +: 7]};
        end else begin
          regQ[`TAR_IX_AR2][`TAR_AR2_EPN +: 20] <= entry.effective_page_number;
        end
        if (upEn) begin
          regQ[`TAR_IX_AR7] <= {28'h0, entry.rpnHi};
        end
        // defaults and search guest fields are left alone here
        regQ[`TAR_IX_AR8] <= {entry.translation_guest_state, entry.vf, 22'h0, entry.translation_partition_id};
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign regView = regQ;

  property p_miss_clear;
    @(posedge clk_sys) disable iff (!rstn)
    (kind == EV_ERR || kind == EV_MISS) |=> regQ[`TAR_IX_AR3] == 32'h0;
  endproperty
  a_miss_clear: assert property (p_miss_clear) else $error("miss left ar3 set");

  property p_hit_copy;
    @(posedge clk_sys) disable iff (!rstn)
    (kind == EV_HIT) |=> regQ[`TAR_IX_AR3][31:12] == $past(entry.rpnLo)
      && regQ[`TAR_IX_AR3][5:0] == $past(entry.perm);
  endproperty
  a_hit_copy: assert property (p_hit_copy) else $error("hit not copied to ar3");

  property p_epn_err;
    @(posedge clk_sys) disable iff (!rstn)
    (kind == EV_ERR) |=> regQ[`TAR_IX_AR2][31:12] == $past(ev.addr[31:12]);
  endproperty
  a_epn_err: assert property (p_epn_err) else $error("epn not from fault address");

  property p_epn_keep;
    @(posedge clk_sys) disable iff (!rstn)
    ((kind == EV_HIT || kind == EV_READ) && !entry.arr) |=>
      regQ[`TAR_IX_AR2][18:12] == $past(regQ[`TAR_IX_AR2][18:12])
      && regQ[`TAR_IX_AR2][31:19] == $past(entry.effective_page_number[19:7]);
  endproperty
  a_epn_keep: assert property (p_epn_keep) else $error("epn low bits lost");

  property p_upper_hold;
    @(posedge clk_sys) disable iff (!rstn)
    (kind != EV_NONE && !upEn && !(wrEn && ix == `TAR_IX_AR7)) |=> $stable(regQ[`TAR_IX_AR7]);
  endproperty
  a_upper_hold: assert property (p_upper_hold) else $error("ar7 changed while off");

  property p_sas_ext;
    @(posedge clk_sys) disable iff (!rstn)
    (kind == EV_ERR && ev.dataErr && ev.extLoad) |=>
      regQ[`TAR_IX_AR6][0] == $past(regQ[`TAR_IX_ELC][31]);
  endproperty
  a_sas_ext: assert property (p_sas_ext) else $error("sas not from load context");

  property p_search_process_id_pid;
    @(posedge clk_sys) disable iff (!rstn)
    (kind == EV_ERR && !ev.extLoad && !ev.extStore) |=>
      regQ[`TAR_IX_AR6][29:16] == $past(regQ[`TAR_IX_CTX][13:0]);
  endproperty
  a_search_process_id_pid: assert property (p_search_process_id_pid) else $error("search_process_id not from pid");

  property p_defaults_stable;
    @(posedge clk_sys) disable iff (!rstn)
    (kind != EV_NONE && !wrEn) |=> $stable(regQ[`TAR_IX_AR4]) && $stable(regQ[`TAR_IX_AR5]);
  endproperty
  a_defaults_stable: assert property (p_defaults_stable) else $error("ar4 or ar5 moved");

  property p_nv_step;
    @(posedge clk_sys) disable iff (!rstn)
    ((kind == EV_ERR || kind == EV_MISS) && !defSel) |=>
      regQ[`TAR_IX_SEL][1:0] == $past(nvCur) + 2'h1 && regQ[`TAR_IX_SEL][17:16] == $past(nvCur);
  endproperty
  a_nv_step: assert property (p_nv_step) else $error("next victim not stepped");

  property p_ready;
    @(posedge clk_sys) disable iff (!rstn)
    (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer not in one cycle");

  c_err: cover property (@(posedge clk_sys) disable iff (!rstn) kind == EV_ERR && ev.extStore);
  c_hit: cover property (@(posedge clk_sys) disable iff (!rstn) kind == EV_HIT && !entry.arr);
  c_miss: cover property (@(posedge clk_sys) disable iff (!rstn) kind == EV_MISS && upEn);
  c_read: cover property (@(posedge clk_sys) disable iff (!rstn) kind == EV_READ && entry.arr);
endmodule : tar_update

// >>> tar_core_model.sv
/*
  behavioural model of the core logic that raises assist register update events;
  assumes the bench calls fire and idle right after a rising edge of clk_sys
*/
`timescale 1ns/100ps
module tar_core_model import tar_pkg::*; (
  input  wire logic clk_sys,
  output tar_evt_t  ev,
  output tar_entry_t entry
);
  initial begin
    ev = '0;
    entry = '0;
  end

  // one event per call, taken at the next edge; calls in a row give back-to-back pulses
  task automatic fire(input tar_evt_t e, input tar_entry_t n);
    ev <= e;
    entry <= n;
    @(posedge clk_sys);
  endtask : fire

  // a stale entry or address is never held, so a design that samples late sees garbage
  task automatic idle();
    ev <= '{addr: ~ev.addr, default: 1'b0};
    entry <= ~entry;
    @(posedge clk_sys);
  endtask : idle
endmodule : tar_core_model

// >>> tar_update_tb.sv
/*
  self-checking bench of tar_update: apb traffic and random update events;
  assumes tar_core_model stands in for the core event logic
*/
`timescale 1ns/100ps
`include "tar_cfg.svh"
module tar_update_tb import tar_pkg::*; ;
  localparam logic [31:0] MSK [12] = '{`TAR_MSK_SEL, `TAR_MSK_AR2, `TAR_MSK_AR3,
    `TAR_MSK_AR4, `TAR_MSK_AR5, `TAR_MSK_AR6, `TAR_MSK_AR7, `TAR_MSK_AR8,
    `TAR_MSK_IMPL, `TAR_MSK_CTX, `TAR_MSK_EXT, `TAR_MSK_EXT};
  logic                       clk_sys, resetn, psel, penable, pwrite;
  logic [31:0]                paddr, pwdata, prdata;
  logic [3:0]                 pstrb;
  logic                       pready, pslverr;
  tar_evt_t                   ev;
  tar_entry_t                 entry;
  logic [`TAR_NREG-1:0][31:0] regView;
  logic [31:0]                xp [12] = '{default: 32'h0};
  logic [1:0]                 nv [64] = '{default: 2'h0};
  int                         n_fail = 0;
  int                         n_compared = 0;

  tar_update #(.NV_SETS(64)) DUT (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ev      (ev),
    .entry   (entry),
    .regView (regView)
  );
  tar_core_model core (.clk_sys(clk_sys), .ev(ev), .entry(entry));

  always #5 clk_sys = ~clk_sys;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_flag

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // live register view against the model, half a cycle after each update edge
  always @(negedge clk_sys) begin
    if (resetn) begin
      for (int i = 0; i < `TAR_NREG; i++) begin
        chk_word(regView[i], xp[i], "regView");
      end
    end
  end

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    logic       ok;
    logic [3:0] ix;
    ix = a[5:2];
    ok = a[31:6] == 26'h0 && a[1:0] == 2'h0 && ix < 4'hC;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no assumed wait count: only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    chk_flag(pready, 1'b1, "pready");
    chk_flag(pslverr, !ok, "pslverr");
    if (!wr) chk_word(prdata, ok ? xp[ix] : 32'h0, "prdata");
    for (int b = 0; b < 4; b++) begin
      if (wr && ok && st[b]) begin
        xp[ix][8*b+:8] = (xp[ix][8*b+:8] & ~MSK[ix][8*b+:8]) | (d[8*b+:8] & MSK[ix][8*b+:8]);
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // expected register file after one event
  function automatic void apply(input tar_evt_t e, input tar_entry_t n);
    logic [5:0]  s;
    logic [31:0] x;
    logic        err;
    s = e.addr[17:12];
    err = e.instErr | e.dataErr;
    x = e.extLoad ? xp[10] : xp[11];
    if (err | e.srchMiss) begin
      xp[1] = {err ? e.addr[31:12] : xp[1][31:12], 5'h0, xp[3][1:0], 5'h0};
      xp[2] = 32'h0;
      if (xp[8][0]) xp[6] = 32'h0;
      xp[0] = xp[3][28] ? 32'h10000000 : {14'h0, nv[s], 14'h0, nv[s] + 2'h1};
      if (!xp[3][28]) nv[s] = nv[s] + 2'h1;
    end else if (e.srchHit | e.entryRead) begin
      xp[1] = {n.arr ? n.effective_page_number : {n.effective_page_number[19:7], xp[1][18:12]}, 5'h0, n.x0, n.x1, 5'h0};
      xp[2] = {n.rpnLo, 2'h0, n.user, n.perm};
      if (xp[8][0]) xp[6] = {28'h0, n.rpnHi};
      xp[7] = {n.translation_guest_state, n.vf, 22'h0, n.translation_partition_id};
      if (e.entryRead) xp[0][1:0] = n.arr ? 2'h0 : nv[s];
      else xp[0] = n.arr ? {4'h1, 6'h0, n.idx, 16'h0} : {14'h0, n.way, 14'h0, nv[s]};
    end
    if (err) begin
      xp[5][0] = (e.extLoad | e.extStore) ? x[31] : e.dataErr ? xp[9][17] : xp[9][16];
      xp[5][29:16] = (e.extLoad | e.extStore) ? x[13:0] : xp[9][13:0];
    end
  endfunction : apply

  initial begin
    tar_evt_t    e;
    tar_entry_t  n;
    logic [95:0] r;
    logic [31:0] d;
    int          k;
    clk_sys = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    void'($urandom(32'hE77CB6E9));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i <= `TAR_NREG; i++) apb(1'b0, 32'(i * 4), 32'h0, 4'h0);
    apb(1'b1, 32'h0, 32'hFFFFFFFF, 4'hF);
    apb(1'b1, 32'h6, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, 32'h100, 32'h0, 4'h0);
    $display("test reset_map done");
    // pass bit 0 enables the upper page update, bit 1 picks the default array
    for (int p = 0; p < 4; p++) begin
      for (int i = 1; i < `TAR_NREG; i++) begin
        d = $urandom;
        d[28] = (i == 3) ? p[1] : d[28];
        d[0] = (i == 8) ? p[0] : d[0];
        apb(1'b1, 32'(i * 4), d, (i == 3 || i == 8) ? 4'hF : 4'($urandom_range(1, 15)));
      end
      for (int i = 0; i < 40; i++) begin
        k = $urandom_range(0, 4);
        r = {$urandom, $urandom, $urandom};
        n = r[74:0];
        e = '0;
        e.addr = $urandom;
        e.addr[17:12] = 6'($urandom_range(0, 3));
        if (i == 0) e.addr = 32'hFFFFFFFF;
        case (k)
          0: e.instErr = 1'b1;
          1: begin
            e.dataErr = 1'b1;
            k = $urandom_range(0, 2);
            e.extLoad = k == 1;
            e.extStore = k == 2;
          end
          2: e.srchHit = 1'b1;
          3: e.srchMiss = 1'b1;
          default: e.entryRead = 1'b1;
        endcase
        if ($urandom_range(0, 3) == 0) core.idle();
        core.fire(e, n);
        apply(e, n);
      end
      core.idle();
      // a write to the read-only select word must leave the event result in place
      apb(1'b1, 32'h0, 32'hFFFFFFFF, 4'hF);
      for (int i = 0; i < `TAR_NREG; i++) apb(1'b0, 32'(i * 4), 32'h0, 4'h0);
      $display("test events pass %0d done", p);
    end
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tar_update_tb
